//--- dv/cms_checker.sv
// Concurrent checks on the ports of the chip mode and security control block.
module cms_checker (
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  input  wire logic              i_dbg_enable,
  input  wire logic              i_dbg_erase_cmd,
  input  wire logic              i_flash_cmd_busy,
  input  wire logic              o_mode_normal,
  input  wire logic              o_secured,
  input  wire logic              o_stop_ack,
  input  wire logic              o_erase_all_req,
  input  wire logic [7:0]        o_flash_clock_divider,
  input  wire cms_pkg::cms_dbg_s o_dbg,
  input  wire cms_pkg::cms_clk_s o_clk,
  input  wire logic              o_flash_cmd_restrict
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sec_hold_a: assert property (!$rose(o_secured))
    else $error("secured flag rose between resets");
  restrict_eq_a: assert property (o_flash_cmd_restrict == o_secured)
    else $error("flash command restriction differs from secured flag");
  mode_hold_a: assert property (!$fell(o_mode_normal))
    else $error("mode bit went from normal back to special");
  erase_req_a: assert property (i_dbg_erase_cmd && i_dbg_enable && !(o_secured && o_mode_normal)
    |=> o_erase_all_req && o_flash_clock_divider == cms_pkg::FLASH_CLKDIV_ERASE)
    else $error("erase command did not reach flash with divider forced");
  erase_src_a: assert property (o_erase_all_req |-> $past(i_dbg_erase_cmd))
    else $error("erase request without debugger command");
  ns_block_a: assert property ((o_secured && o_mode_normal)[*2] |-> !o_dbg.enabled)
    else $error("debug enabled in secured normal mode");
  ss_block_a: assert property ((o_secured && !o_mode_normal && o_dbg.enabled)[*2]
    |-> !o_dbg.mem_access_ok && o_dbg.erase_cmd_ok && o_dbg.status_cmd_ok)
    else $error("secured special mode debug gating wrong");
  stop_busy_a: assert property (o_stop_ack |-> !$past(i_flash_cmd_busy))
    else $error("stop acknowledged during flash command");
  stop_gate_a: assert property (o_stop_ack && !i_dbg_enable
    |-> !o_clk.core_clk_en && !o_clk.bus_clk_en && !o_clk.periph_en)
    else $error("clocks still running in stop");
  dbg_stop_a: assert property (o_stop_ack && o_dbg.enabled
    |-> o_clk.voltage_regulator_full_perf && o_clk.supply_mon_en && o_clk.dbg_serial_clk_en)
    else $error("debug support lost in stop");

  erase_c: cover property (o_erase_all_req);
  stop_c: cover property (o_stop_ack && !o_clk.osc_en);
  halt_c: cover property (o_dbg.halt_state && o_secured);
endmodule : cms_checker

bind cms_chip_mode_ctrl cms_checker i_cms_checker (
  .i_clk_sys, .i_reset_n, .i_dbg_enable, .i_dbg_erase_cmd, .i_flash_cmd_busy, .o_mode_normal, .o_secured,
  .o_stop_ack, .o_erase_all_req, .o_flash_clock_divider, .o_dbg, .o_clk, .o_flash_cmd_restrict
);

//--- dv/cms_flash_model.sv
// Flash side model: hands over the option byte after reset and answers erase-all.
module cms_flash_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic       i_prog,
  input  wire logic [7:0] i_prog_byte,
  input  wire logic       i_busy,
  input  wire logic       i_erase_all_req,
  output logic [7:0]      o_option_byte,
  output logic            o_load_done = 1'b0,
  output logic            o_cmd_busy,
  output logic            o_erase_ok = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] stored = 8'hA6;
  logic [3:0] cnt    = 4'h0;
  logic [2:0] ers    = 3'h0;

  assign o_cmd_busy = i_busy;
  // Outside the load strobe the lines show the inverse, so a late sample is caught.
  assign o_option_byte = o_load_done ? stored : ~stored;

  always @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt         <= 4'h0;
      o_load_done <= 1'b0;
    end
    else
    begin
      if (cnt != 4'hF)
        cnt <= cnt + 4'h1;
      o_load_done <= (cnt == 4'h5);
    end
  end

  always @(posedge i_clk_sys)
  begin
    ers        <= {ers[1:0], i_erase_all_req};
    o_erase_ok <= ers[2];
    if (i_prog)
      stored <= i_prog_byte;
    else if (ers[2])
      stored <= {stored[7:2], cms_pkg::SEC_UNSECURED};
  end
endmodule : cms_flash_model

//--- dv/tb_top.sv
// Self-checking bench for the chip mode and security control block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_reset_n, i_mode_select_input, i_dbg_enable, i_dbg_erase_cmd, i_wait_instruction, i_stop_instruction;
  logic i_wake_periodic, i_wr, i_rd, prog, busy, i_flash_load_done, i_flash_cmd_busy, i_erase_done_ok;
  logic o_mode_normal, o_secured, o_stop_ack, o_erase_all_req, o_flash_cmd_restrict;
  logic [2:0] ws, wk;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, prog_byte, i_flash_option_byte, o_rdata, o_flash_clock_divider;
  logic [8:0] cexp [4] = '{9'h020, 9'h000, 9'h1E7, 9'h063};
  logic [8:0] cmsk [4] = '{9'h1A4, 9'h1B4, 9'h1E7, 9'h1E7};
  cms_pkg::cms_dbg_s o_dbg;
  cms_pkg::cms_clk_s o_clk;
  int err_total = 0;
  int tests_run = 0;

  always #4 i_clk_sys = ~i_clk_sys;

  cms_chip_mode_ctrl i_cms_chip_mode_ctrl (
    .i_clk_sys, .i_reset_n, .i_mode_select_input, .i_flash_option_byte, .i_flash_load_done, .i_flash_cmd_busy,
    .i_erase_done_ok, .i_dbg_enable, .i_dbg_erase_cmd, .i_wait_instruction, .i_stop_instruction,
    .i_nonmaskable_interrupt_pin(ws[0]), .i_irq_pin(ws[1]), .i_unmasked_irq(ws[2]), .i_wake_key(wk[0]),
    .i_wake_sci(wk[1]), .i_wake_can(wk[2]), .i_wake_periodic, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_mode_normal, .o_secured, .o_stop_ack, .o_erase_all_req, .o_flash_clock_divider, .o_dbg, .o_clk,
    .o_flash_cmd_restrict
  );

  cms_flash_model i_cms_flash_model (
    .i_clk_sys, .i_reset_n, .i_prog(prog), .i_prog_byte(prog_byte), .i_busy(busy),
    .i_erase_all_req(o_erase_all_req), .o_option_byte(i_flash_option_byte), .o_load_done(i_flash_load_done),
    .o_cmd_busy(i_flash_cmd_busy), .o_erase_ok(i_erase_done_ok)
  );

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input string n, input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(n, {1'b0, e & m}, {1'b0, o_rdata & m});
  endtask : rd_chk

  // The flash image survives reset unless p asks for a new byte, as a real array would.
  task automatic do_reset(input logic m, input logic p, input logic [7:0] b);
    @(posedge i_clk_sys);
    prog                <= p;
    prog_byte           <= b;
    i_reset_n           <= 1'b0;
    i_mode_select_input <= m;
    @(posedge i_clk_sys);
    prog <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    cyc(14);
  endtask : do_reset

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic m, sd, en;
    logic [1:0] sb;
    int t;
    {i_reset_n, i_mode_select_input, i_dbg_erase_cmd, i_wait_instruction, i_stop_instruction, i_wake_periodic,
     i_wr, i_rd, prog, busy, ws, wk, i_addr, i_wdata, prog_byte} = '0;
    i_dbg_enable = 1'b1;
    for (int s = 0; s < 8; s++)
    begin
      m  = s[0];
      sb = s[2:1];
      sd = (sb != cms_pkg::SEC_UNSECURED);
      en = !(sd && m);
      do_reset(m, 1'b1, {6'h29, sb});
      chk("mode", {8'h0, m}, {8'h0, o_mode_normal});
      chk("secured", {8'h0, sd}, {8'h0, o_secured});
      chk("restrict", {8'h0, sd}, {8'h0, o_flash_cmd_restrict});
      rd_chk("flash_security_register", cms_pkg::ADDR_FLASH_SECURITY_REGISTER, {6'h29, sb}, 8'hFF);
      chk("dbg", {4'h0, en, !m, en && !sd, en, en}, {4'h0, o_dbg});
      if (sb == cms_pkg::SEC_RECOMMENDED && !m)
      begin
        // Erase is issued straight after reset, before any bus frequency change.
        @(posedge i_clk_sys);
        i_dbg_erase_cmd <= 1'b1;
        @(posedge i_clk_sys);
        i_dbg_erase_cmd <= 1'b0;
        #1;
        chk("erase req", {8'h0, 1'b1}, {8'h0, o_erase_all_req});
        chk("divider", {1'b0, cms_pkg::FLASH_CLKDIV_ERASE}, {1'b0, o_flash_clock_divider});
        cyc(1);
        chk("erase end", 9'h0, {8'h0, o_erase_all_req});
        cyc(8);
        rd_chk("erase ok", cms_pkg::ADDR_STATUS, 8'h20, 8'h20);
        rd_chk("div rd", cms_pkg::ADDR_CLKDIV, cms_pkg::FLASH_CLKDIV_ERASE, 8'hFF);
        do_reset(1'b0, 1'b0, 8'h00);
        chk("unsecured", 9'h0, {8'h0, o_secured});
      end
      if (!m)
      begin
        reg_wr(cms_pkg::ADDR_MODE, 8'h01);
        cyc(2);
        chk("mode up", 9'h1, {8'h0, o_mode_normal});
        reg_wr(cms_pkg::ADDR_MODE, 8'h00);
        cyc(2);
        chk("mode kept", 9'h1, {8'h0, o_mode_normal});
      end
    end
    do_reset(1'b1, 1'b1, 8'hA6);
    rd_chk("unmapped", 4'hF, 8'h00, 8'hFF);
    reg_wr(cms_pkg::ADDR_CLKDIV, 8'h3C);
    rd_chk("div wr", cms_pkg::ADDR_CLKDIV, 8'h3C, 8'hFF);
    rd_chk("power rst", cms_pkg::ADDR_POWER, cms_pkg::POWER_RESET, 8'hFF);
    rd_chk("wake rst", cms_pkg::ADDR_WAKE, cms_pkg::WAKE_RESET, 8'hFF);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge i_clk_sys);
      i_wait_instruction <= 1'b1;
      @(posedge i_clk_sys);
      i_wait_instruction <= 1'b0;
      cyc(1);
      chk("wait clk", 9'h004, o_clk & 9'h104);
      rd_chk("wait mode", cms_pkg::ADDR_STATUS, 8'h01, 8'h03);
      @(posedge i_clk_sys);
      ws[k] <= 1'b1;
      @(posedge i_clk_sys);
      ws[k] <= 1'b0;
      cyc(2);
      rd_chk("wait wake", cms_pkg::ADDR_STATUS, 8'h00, 8'h03);
    end
    for (int k = 0; k < 4; k++)
    begin
      reg_wr(cms_pkg::ADDR_POWER, {6'h0, k == 2, k == 0});
      reg_wr(cms_pkg::ADDR_WAKE, 8'h01 << (k % 3));
      @(posedge i_clk_sys);
      i_dbg_enable       <= (k > 1);
      busy               <= 1'b1;
      i_stop_instruction <= 1'b1;
      cyc(4);
      chk("stop busy", 9'h0, {8'h0, o_stop_ack});
      @(posedge i_clk_sys);
      busy <= 1'b0;
      for (t = 0; t < 20 && o_stop_ack !== 1'b1; t++)
        cyc(1);
      if (t == 20)
      begin
        err_total++;
        finish_test();
      end
      chk("stop clk", cexp[k], o_clk & cmsk[k]);
      @(posedge i_clk_sys);
      i_stop_instruction <= 1'b0;
      wk[(k + 1) % 3]    <= 1'b1;
      cyc(3);
      rd_chk("stop mode", cms_pkg::ADDR_STATUS, (k == 0) ? 8'h02 : 8'h03, 8'h03);
      @(posedge i_clk_sys);
      {i_wake_periodic, wk} <= 4'h1 << k;
      @(posedge i_clk_sys);
      {i_wake_periodic, wk} <= 4'h0;
      cyc(2);
      rd_chk("stop wake", cms_pkg::ADDR_STATUS, 8'h00, 8'h03);
    end
    finish_test();
  end
endmodule : tb_top

//--- src/cms_chip_mode_ctrl.sv
// Chip operating mode, low-power sequencing and flash security control.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
module cms_chip_mode_ctrl (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire logic             i_mode_select_input,
  input  wire logic [7:0]       i_flash_option_byte,
  input  wire logic             i_flash_load_done,
  input  wire logic             i_flash_cmd_busy,
  input  wire logic             i_erase_done_ok,
  input  wire logic             i_dbg_enable,
  input  wire logic             i_dbg_erase_cmd,
  input  wire logic             i_wait_instruction,
  input  wire logic             i_stop_instruction,
  input  wire logic             i_nonmaskable_interrupt_pin,
  input  wire logic             i_irq_pin,
  input  wire logic             i_unmasked_irq,
  input  wire logic             i_wake_key,
  input  wire logic             i_wake_sci,
  input  wire logic             i_wake_can,
  input  wire logic             i_wake_periodic,
  input  wire logic [3:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic [7:0]            o_rdata,
  output logic                  o_mode_normal,
  output logic                  o_secured,
  output logic                  o_stop_ack,
  output logic                  o_erase_all_req,
  output logic [7:0]            o_flash_clock_divider,
  output cms_pkg::cms_dbg_s     o_dbg,
  output cms_pkg::cms_clk_s     o_clk,
  output logic                  o_flash_cmd_restrict
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Mode capture and mode register
  // ----------------------------------------------------------------
  // The strap is sampled on the first clock after release, since an
  // asynchronous reset may only load constants.
  logic mode_bit;
  logic mode_captured;
  logic mode_wr;
  logic dbg_halt;

  assign mode_wr = i_wr && (i_addr == cms_pkg::ADDR_MODE);

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_bit      <= cms_pkg::MODE_SPECIAL;
      mode_captured <= 1'b0;
      dbg_halt      <= 1'b0;
    end
    else if (!mode_captured)
    begin
      mode_bit      <= i_mode_select_input;
      mode_captured <= 1'b1;
      dbg_halt      <= (i_mode_select_input == cms_pkg::MODE_SPECIAL);
    end
    else if (mode_wr && i_wdata[0] == cms_pkg::MODE_NORMAL)
    begin
      mode_bit <= cms_pkg::MODE_NORMAL;
      dbg_halt <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Security register
  // ----------------------------------------------------------------
  logic [7:0] flash_security_register;
  logic       flash_security_register_loaded;
  logic       secured;

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_security_register        <= cms_pkg::FLASH_SECURITY_REGISTER_RESET;
      flash_security_register_loaded <= 1'b0;
    end
    else if (!flash_security_register_loaded && i_flash_load_done)
    begin
      flash_security_register        <= i_flash_option_byte;
      flash_security_register_loaded <= 1'b1;
    end
  end

  // Secured until the copy lands, so nothing leaks during the load window.
  assign secured = !flash_security_register_loaded ||
                   (flash_security_register[cms_pkg::SEC_LSB +: 2] != cms_pkg::SEC_UNSECURED);

  // ----------------------------------------------------------------
  // Debug gating
  // ----------------------------------------------------------------
  logic dbg_active;
  logic special;

  assign special    = mode_captured && (mode_bit == cms_pkg::MODE_SPECIAL);
  assign dbg_active = i_dbg_enable && !(secured && !special);

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_dbg                <= '0;
      o_flash_cmd_restrict <= 1'b1;
      o_secured            <= 1'b1;
      o_mode_normal        <= 1'b0;
    end
    else
    begin
      o_dbg.enabled        <= dbg_active;
      o_dbg.halt_state     <= dbg_halt;
      o_dbg.mem_access_ok  <= dbg_active && !secured;
      o_dbg.erase_cmd_ok   <= dbg_active;
      o_dbg.status_cmd_ok  <= dbg_active;
      o_flash_cmd_restrict <= secured;
      o_secured            <= secured;
      o_mode_normal        <= mode_bit;
    end
  end

  // ----------------------------------------------------------------
  // Flash erase and divider
  // ----------------------------------------------------------------
  logic erase_go;
  assign erase_go = i_dbg_erase_cmd && dbg_active;

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_erase_all_req       <= 1'b0;
      o_flash_clock_divider <= 8'h00;
    end
    else
    begin
      o_erase_all_req <= erase_go;
      if (erase_go)
      begin
        o_flash_clock_divider <= cms_pkg::FLASH_CLKDIV_ERASE;
      end
      else if (i_wr && i_addr == cms_pkg::ADDR_CLKDIV)
      begin
        o_flash_clock_divider <= i_wdata;
      end
    end
  end

  // A completed erase only unsecures after the flash reprograms the byte
  // and the next reset reloads it; the flash side owns that step.
  logic erase_ok_seen;

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      erase_ok_seen <= 1'b0;
    end
    else if (i_erase_done_ok)
    begin
      erase_ok_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power control registers
  // ----------------------------------------------------------------
  logic [7:0] power_cfg;
  logic [7:0] wake_cfg;

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_cfg <= cms_pkg::POWER_RESET;
      wake_cfg  <= cms_pkg::WAKE_RESET;
    end
    else if (i_wr)
    begin
      if (i_addr == cms_pkg::ADDR_POWER)
      begin
        power_cfg <= i_wdata;
      end
      if (i_addr == cms_pkg::ADDR_WAKE)
      begin
        wake_cfg <= i_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power mode sequencer
  // ----------------------------------------------------------------
  cms_pkg::cms_power_e pmode;
  cms_pkg::cms_power_e next_pmode;
  logic                stop_wake;
  logic                wait_wake;
  logic                stop_ok;

  assign wait_wake = i_nonmaskable_interrupt_pin || i_irq_pin || i_unmasked_irq;
  assign stop_wake = i_nonmaskable_interrupt_pin || i_irq_pin || i_wake_periodic ||
                     (wake_cfg[cms_pkg::WAKE_KEY_BIT] && i_wake_key) ||
                     (wake_cfg[cms_pkg::WAKE_SCI_BIT] && i_wake_sci) ||
                     (wake_cfg[cms_pkg::WAKE_CAN_BIT] && i_wake_can);
  assign stop_ok   = i_stop_instruction && !i_flash_cmd_busy;

  always_comb
  begin
    next_pmode = pmode;
    case (pmode)
      cms_pkg::PM_RUN:
      begin
        if (stop_ok)
        begin
          next_pmode = power_cfg[cms_pkg::PWR_PSTOP_BIT] ? cms_pkg::PM_PSTOP : cms_pkg::PM_STOP;
        end
        else if (i_wait_instruction)
        begin
          next_pmode = cms_pkg::PM_WAIT;
        end
      end
      cms_pkg::PM_WAIT:
      begin
        if (wait_wake)
        begin
          next_pmode = cms_pkg::PM_RUN;
        end
      end
      cms_pkg::PM_PSTOP,
      cms_pkg::PM_STOP:
      begin
        if (stop_wake)
        begin
          next_pmode = cms_pkg::PM_RUN;
        end
      end
      default:
      begin
        next_pmode = cms_pkg::PM_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pmode      <= cms_pkg::PM_RUN;
      o_stop_ack <= 1'b0;
    end
    else
    begin
      pmode      <= next_pmode;
      o_stop_ack <= (pmode == cms_pkg::PM_RUN) && stop_ok;
    end
  end

  // ----------------------------------------------------------------
  // Clock and supply enables
  // ----------------------------------------------------------------
  logic     keep_alive;
  logic     dbg_in_stop;
  cms_pkg::cms_clk_s next_clk;

  assign keep_alive  = power_cfg[cms_pkg::PWR_KEEP_BIT];
  assign dbg_in_stop = dbg_active;

  always_comb
  begin
    next_clk = '1;
    case (next_pmode)
      cms_pkg::PM_WAIT:
      begin
        next_clk.core_clk_en = 1'b0;
      end
      cms_pkg::PM_PSTOP,
      cms_pkg::PM_STOP:
      begin
        if (dbg_in_stop)
        begin
          next_clk.voltage_regulator_full_perf    = 1'b1;
          next_clk.osc_en            = 1'b1;
          next_clk.supply_mon_en     = 1'b1;
          next_clk.dbg_serial_clk_en = 1'b1;
          next_clk.core_clk_en       = keep_alive;
          next_clk.bus_clk_en        = keep_alive;
          next_clk.periph_en         = keep_alive;
          next_clk.rti_wdog_en       = keep_alive || (next_pmode == cms_pkg::PM_PSTOP);
          next_clk.api_en            = 1'b1;
        end
        else
        begin
          next_clk.core_clk_en       = 1'b0;
          next_clk.bus_clk_en        = 1'b0;
          next_clk.dbg_serial_clk_en = 1'b0;
          next_clk.periph_en         = 1'b0;
          next_clk.voltage_regulator_full_perf    = 1'b0;
          next_clk.supply_mon_en     = 1'b0;
          next_clk.osc_en            = (next_pmode == cms_pkg::PM_PSTOP);
          next_clk.rti_wdog_en       = (next_pmode == cms_pkg::PM_PSTOP);
        end
      end
      default:
      begin
        next_clk = '1;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_clk <= '1;
    end
    else
    begin
      o_clk <= next_clk;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_rd)
    begin
      case (i_addr)
        cms_pkg::ADDR_MODE:   o_rdata <= {7'h00, mode_bit};
        cms_pkg::ADDR_FLASH_SECURITY_REGISTER:   o_rdata <= flash_security_register;
        cms_pkg::ADDR_POWER:  o_rdata <= power_cfg;
        cms_pkg::ADDR_WAKE:   o_rdata <= wake_cfg;
        cms_pkg::ADDR_STATUS: o_rdata <= {2'h0, erase_ok_seen, dbg_halt, secured, 1'b0, pmode[1:0]};
        cms_pkg::ADDR_CLKDIV: o_rdata <= o_flash_clock_divider;
        default:              o_rdata <= 8'h00;
      endcase
    end
    else
    begin
      o_rdata <= 8'h00;
    end
  end

endmodule : cms_chip_mode_ctrl

//--- src/cms_pkg.sv
// Package of constants and carrier types for the chip mode and security control block.
package cms_pkg;

  // ----------------------------------------------------------------
  // Chip modes and security
  // ----------------------------------------------------------------
  localparam logic       MODE_NORMAL       = 1'h1;
  localparam logic       MODE_SPECIAL      = 1'h0;
  localparam logic [1:0] SEC_UNSECURED     = 2'h2;
  localparam logic [1:0] SEC_RECOMMENDED   = 2'h1;
  localparam int         SEC_LSB           = 0;
  localparam logic [7:0] FLASH_SECURITY_REGISTER_RESET        = 8'h00;
  localparam logic [7:0] FLASH_CLKDIV_ERASE = 8'h05;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE     = 4'h0;
  localparam logic [3:0] ADDR_FLASH_SECURITY_REGISTER     = 4'h1;
  localparam logic [3:0] ADDR_POWER    = 4'h2;
  localparam logic [3:0] ADDR_WAKE     = 4'h3;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_CLKDIV   = 4'h5;
  localparam int         PWR_PSTOP_BIT = 0;
  localparam int         PWR_KEEP_BIT  = 1;
  localparam int         WAKE_KEY_BIT  = 0;
  localparam int         WAKE_SCI_BIT  = 1;
  localparam int         WAKE_CAN_BIT  = 2;
  localparam logic [7:0] POWER_RESET   = 8'h00;
  localparam logic [7:0] WAKE_RESET    = 8'h00;

  typedef enum logic [2:0] {
    PM_RUN,
    PM_WAIT,
    PM_PSTOP,
    PM_STOP
  } cms_power_e;

  // Clock and supply enables toward the clock and power unit.
  typedef struct packed {
    logic core_clk_en;
    logic bus_clk_en;
    logic dbg_serial_clk_en;
    logic osc_en;
    logic rti_wdog_en;
    logic api_en;
    logic periph_en;
    logic voltage_regulator_full_perf;
    logic supply_mon_en;
  } cms_clk_s;

  // Debug access gating toward the debug controller.
  typedef struct packed {
    logic enabled;
    logic halt_state;
    logic mem_access_ok;
    logic erase_cmd_ok;
    logic status_cmd_ok;
  } cms_dbg_s;

endpackage : cms_pkg
